// File: rtl/adc_dma_map.svh
// register offsets, field positions and reset values of the result dma
// assumes: included by bare name; definitions only
`ifndef ADC_DMA_MAP_SVH
`define ADC_DMA_MAP_SVH

`define OFS_RESULT_COUNT     16'h0000
`define OFS_IRQ_FLAGS        16'ha810
`define OFS_IRQ_ENABLE       16'ha850
`define OFS_TRANSFER_CFG     16'hd010
`define OFS_TRANSFER_STATUS  16'hd014
`define OFS_BUFFER_START     16'hd018
`define OFS_BUFFER_SIZE      16'hd01c
`define OFS_NEXT_ADDRESS     16'hd020

`define RST_BUFFER_START     32'h2000_0000
`define RST_NEXT_ADDRESS     32'h2000_0000
`define RST_ZERO             32'h0000_0000

`define BIT_CFG_LOAD         0
`define BIT_CFG_WRAP         1
`define BIT_CFG_RESET        4
`define BIT_STAT_ACTIVE      0
`define BIT_STAT_OVERFLOW    1

`define BIT_IRQ_HALF         1
`define BIT_IRQ_FULL         2
`define BIT_IRQ_SAT          3
`define BIT_IRQ_OVF          4

`endif

// File: rtl/adc_dma_pkg.sv
// types shared by the result dma and its interrupt unit
// assumes: the map header carries the numbers
package adc_dma_pkg;
	typedef enum logic [0:0] {
		st_idle   = 1'b0,
		st_active = 1'b1
	} engine_state_e;
	typedef logic [4:1] irq_bits_t;
endpackage : adc_dma_pkg

// File: rtl/irq_link.sv
// signals between the transfer engine and its second-level event unit
// assumes: one clock; strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface irq_link;
	adc_dma_pkg::irq_bits_t set_events;
	logic                   flag_clear;
	adc_dma_pkg::irq_bits_t clear_bits;
	logic                   enable_write;
	adc_dma_pkg::irq_bits_t enable_bits;
	adc_dma_pkg::irq_bits_t flags;
	adc_dma_pkg::irq_bits_t enable;

	modport engine (
		output set_events, flag_clear, clear_bits, enable_write,
		output enable_bits,
		input  flags, enable
	);
	modport events (
		input  set_events, flag_clear, clear_bits, enable_write,
		input  enable_bits,
		output flags, enable
	);
endinterface : irq_link
`default_nettype wire

// File: rtl/second_level_event_unit.sv
// pending flags, enable mask and the combined interrupt request
// assumes: driven by the engine over irq_link on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "adc_dma_map.svh"
module second_level_event_unit (
	// system
	input  wire logic clock,
	input  wire logic arst_n,
	// engine side
	irq_link.events   link,
	// toward the top-level interrupt controller
	output logic      irq
);
	adc_dma_pkg::irq_bits_t flags;
	adc_dma_pkg::irq_bits_t enable;
	adc_dma_pkg::irq_bits_t cleared;

	// a flag cleared in the cycle its event arrives stays set
	assign cleared = link.flag_clear ? link.clear_bits : '0;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~cleared) | link.set_events;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable <= '0;
		end else if (link.enable_write) begin
			enable <= link.enable_bits;
		end
	end

	// top-level masking lives in the controller, not here
	assign irq = |(flags & enable);
	assign link.flags  = flags;
	assign link.enable = enable;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// a rise needs an enabled event or a fresh enable one cycle earlier
	a_irq_level: assert property (
		$rose(irq) |-> (($past(link.set_events) & $past(enable)) != '0)
		|| $past(link.enable_write))
		else $error("irq rose without an enabled event");
	a_set_beats_clear: assert property (
		(link.set_events != '0) |=> ((flags & $past(link.set_events))
		== $past(link.set_events)))
		else $error("event lost against clear");
	a_clear_one: assert property (
		(link.flag_clear && link.set_events == '0)
		|=> ((flags & $past(link.clear_bits)) == '0))
		else $error("write of one did not clear flag");
endmodule : second_level_event_unit
`default_nettype wire

// File: rtl/adc_result_dma.sv
// converter result dma: apb registers, ram write engine, events
// assumes: one 25 MHz clock; results and ram port on that clock;
// ram accepts a write every cycle; apb slave answers with no wait
//
// Contract
// - start address holds 13 bits, bit 0 forced to zero.
// - buffer size is 12 bits, counted in 16-bit results.
// - next-write halfword address readable in bits 12 to 1.
// - readable 12-bit count of results written so far; wrap mode sets it back to zero at each wrap.
// - overflow sets pending flag bit 4.
// - gain saturation sets pending flag bit 3.
// - buffer full sets pending flag bit 2.
// - buffer half full sets pending flag bit 1.
// - enable bits 4 to 1 match the pending flags.
// - enabled sources combine into one interrupt request.
// - top-level mask gates whole block; sources chosen by enables.
// - linear mode stops the engine when the buffer fills.
// - wrap mode restarts at buffer start when full.
// - load starts the engine, writing zero does nothing, self-clears.
// - result arriving while inactive records an overflow.
`timescale 1ns/10ps
`default_nettype none
`include "adc_dma_map.svh"
module adc_result_dma (
	// system
	input  wire logic        clock,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// converter results
	input  wire logic        result_valid,
	input  wire logic [15:0] result_data,
	input  wire logic        result_saturated,
	// ram write port
	output logic             ram_write,
	output logic      [12:0] ram_address,
	output logic      [15:0] ram_data,
	// interrupt request
	output logic             irq
);
	adc_dma_pkg::engine_state_e state;
	logic [12:1] start_address;
	logic [11:0] size_value;
	logic [12:1] current;
	logic [11:0] count;
	logic        wrap_mode;
	logic        overflow_status;
	logic [11:0] next_count;
	logic        hit_half;
	logic        hit_full;
	logic        access;
	logic        setup;
	logic        wr;
	logic        load_req;
	logic        reset_req;
	logic        taken;
	logic        lost;
	logic        mapped;

	irq_link link ();

	second_level_event_unit u_events (
		.clock  (clock),
		.arst_n (arst_n),
		.link   (link),
		.irq    (irq)
	);

	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction : hit

	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign wr      = access && pwrite;
	assign pready  = 1'b1;
	assign mapped  = hit(paddr, `OFS_RESULT_COUNT) || hit(paddr, `OFS_IRQ_FLAGS)
		|| hit(paddr, `OFS_IRQ_ENABLE) || hit(paddr, `OFS_TRANSFER_CFG)
		|| hit(paddr, `OFS_TRANSFER_STATUS) || hit(paddr, `OFS_BUFFER_START)
		|| hit(paddr, `OFS_BUFFER_SIZE) || hit(paddr, `OFS_NEXT_ADDRESS);
	// unmapped addresses answer with an error and read zero
	assign pslverr = access && !mapped;

	// load acts only as a pulse and loses to reset; the bit itself never reads back set
	assign load_req  = wr && hit(paddr, `OFS_TRANSFER_CFG)
		&& pwdata[`BIT_CFG_LOAD];
	assign reset_req = wr && hit(paddr, `OFS_TRANSFER_CFG)
		&& pwdata[`BIT_CFG_RESET];

	assign taken      = result_valid && state == adc_dma_pkg::st_active;
	assign lost       = result_valid && state == adc_dma_pkg::st_idle;
	assign next_count = count + 12'h001;
	assign hit_half   = (size_value > 12'h001)
		&& next_count == {1'b0, size_value[11:1]};
	assign hit_full   = next_count == size_value;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			start_address <= 12'(`RST_BUFFER_START >> 1);
			size_value    <= 12'h000;
			wrap_mode     <= 1'b0;
		end else if (wr) begin
			if (hit(paddr, `OFS_BUFFER_START))
				start_address <= pwdata[12:1];
			if (hit(paddr, `OFS_BUFFER_SIZE))
				size_value <= pwdata[11:0];
			if (hit(paddr, `OFS_TRANSFER_CFG))
				wrap_mode <= pwdata[`BIT_CFG_WRAP];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state   <= adc_dma_pkg::st_idle;
			current <= 12'(`RST_NEXT_ADDRESS >> 1);
			count   <= 12'h000;
		end else if (reset_req) begin
			state   <= adc_dma_pkg::st_idle;
			current <= start_address;
			count   <= 12'h000;
		end else if (load_req) begin
			state   <= adc_dma_pkg::st_active;
			current <= start_address;
			count   <= 12'h000;
		end else if (taken) begin
			if (hit_full && wrap_mode) begin
				current <= start_address;
				count   <= 12'h000;
			end else begin
				current <= current + 12'h001;
				count   <= next_count;
				if (hit_full)
					state <= adc_dma_pkg::st_idle;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			overflow_status <= 1'b0;
		end else if (reset_req) begin
			overflow_status <= 1'b0;
		end else if (lost) begin
			overflow_status <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ram_write   <= 1'b0;
			ram_address <= 13'h0000;
			ram_data    <= 16'h0000;
		end else begin
			ram_write <= taken;
			if (taken) begin
				ram_address <= {current, 1'b0};
				ram_data    <= result_data;
			end
		end
	end

	always_comb begin
		link.set_events = '0;
		link.set_events[`BIT_IRQ_OVF]  = lost;
		link.set_events[`BIT_IRQ_SAT]  = result_valid && result_saturated;
		link.set_events[`BIT_IRQ_FULL] = taken && hit_full;
		link.set_events[`BIT_IRQ_HALF] = taken && hit_half;
	end
	// bit 0 is reserved; software keeps it at one or zero as documented
	assign link.flag_clear   = wr && hit(paddr, `OFS_IRQ_FLAGS);
	assign link.clear_bits   = pwdata[4:1];
	assign link.enable_write = wr && hit(paddr, `OFS_IRQ_ENABLE);
	assign link.enable_bits  = pwdata[4:1];

	// read data latched in setup so it is steady for the access phase
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= `RST_ZERO;
		end else if (setup) begin
			prdata <= `RST_ZERO;
			if (hit(paddr, `OFS_RESULT_COUNT))
				prdata[11:0] <= count;
			if (hit(paddr, `OFS_IRQ_FLAGS))
				prdata[4:1] <= link.flags;
			if (hit(paddr, `OFS_IRQ_ENABLE))
				prdata[4:1] <= link.enable;
			if (hit(paddr, `OFS_TRANSFER_CFG))
				prdata[`BIT_CFG_WRAP] <= wrap_mode;
			if (hit(paddr, `OFS_TRANSFER_STATUS)) begin
				prdata[`BIT_STAT_ACTIVE]   <= state == adc_dma_pkg::st_active;
				prdata[`BIT_STAT_OVERFLOW] <= overflow_status;
			end
			if (hit(paddr, `OFS_BUFFER_START))
				prdata[12:0] <= {start_address, 1'b0};
			if (hit(paddr, `OFS_BUFFER_SIZE))
				prdata[11:0] <= size_value;
			if (hit(paddr, `OFS_NEXT_ADDRESS))
				prdata[12:0] <= {current, 1'b0};
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_load;
		load_req && !reset_req;
	endsequence
	sequence s_fill_linear;
		taken && hit_full && !wrap_mode && !load_req && !reset_req;
	endsequence
	sequence s_fill_wrap;
		taken && hit_full && wrap_mode && !load_req && !reset_req;
	endsequence

	a_start_even: assert property (
		(wr && hit(paddr, `OFS_BUFFER_START))
		|=> start_address == $past(pwdata[12:1]))
		else $error("start address not stored");
	a_size_store: assert property (
		(wr && hit(paddr, `OFS_BUFFER_SIZE))
		|=> size_value == $past(pwdata[11:0]))
		else $error("size not stored");
	a_addr_step: assert property (
		(taken && !hit_full && !load_req && !reset_req)
		|=> current == $past(current) + 12'h001 && ram_write
		&& ram_address == {$past(current), 1'b0})
		else $error("address did not advance");
	a_count_step: assert property (
		(taken && !hit_full && !load_req && !reset_req)
		|=> count == $past(count) + 12'h001)
		else $error("count did not advance");
	a_ovf_flag: assert property (
		(lost && !reset_req)
		|=> link.flags[`BIT_IRQ_OVF] && overflow_status)
		else $error("overflow not flagged");
	a_sat_flag: assert property (
		(result_valid && result_saturated) |=> link.flags[`BIT_IRQ_SAT])
		else $error("saturation not flagged");
	a_full_flag: assert property (
		(taken && hit_full) |=> link.flags[`BIT_IRQ_FULL])
		else $error("full not flagged");
	a_half_flag: assert property (
		(taken && hit_half) |=> link.flags[`BIT_IRQ_HALF])
		else $error("half not flagged");
	a_linear_stop: assert property (
		s_fill_linear |=> state == adc_dma_pkg::st_idle)
		else $error("linear mode kept running");
	a_wrap_restart: assert property (
		s_fill_wrap |=> state == adc_dma_pkg::st_active
		&& current == $past(start_address) && count == 12'h000)
		else $error("wrap did not restart");
	a_load_start: assert property (
		s_load |=> state == adc_dma_pkg::st_active && count == 12'h000)
		else $error("load did not start engine");

	a_load_addr: assert property (
		s_load |=> current == $past(start_address))
		else $error("load did not reload address");
	a_cfg_reads: assert property (
		(setup && hit(paddr, `OFS_TRANSFER_CFG))
		|=> !prdata[`BIT_CFG_LOAD] && !prdata[`BIT_CFG_RESET])
		else $error("self-clearing bit read back set");
	a_reset_clears: assert property (
		reset_req |=> state == adc_dma_pkg::st_idle && !overflow_status)
		else $error("engine reset left state behind");
	a_idle_no_write: assert property (
		lost |=> !ram_write)
		else $error("result written while idle");
	a_idle_hold: assert property (
		(state == adc_dma_pkg::st_idle && !load_req && !reset_req)
		|=> count == $past(count) && current == $past(current))
		else $error("idle engine moved");
	a_ram_even: assert property (
		ram_write |-> !ram_address[0])
		else $error("ram address odd");
	a_start_read: assert property (
		(setup && hit(paddr, `OFS_BUFFER_START))
		|=> !prdata[0] && prdata[31:13] == 19'h0_0000)
		else $error("start address read not even");
	a_next_read: assert property (
		(setup && hit(paddr, `OFS_NEXT_ADDRESS))
		|=> prdata[12:0] == {$past(current), 1'b0})
		else $error("next address read wrong");
	a_count_read: assert property (
		(setup && hit(paddr, `OFS_RESULT_COUNT))
		|=> prdata[11:0] == $past(count) && prdata[31:12] == 20'h0_0000)
		else $error("count read wrong");
	a_size_read: assert property (
		(setup && hit(paddr, `OFS_BUFFER_SIZE))
		|=> prdata[11:0] == $past(size_value) && prdata[31:12] == 20'h0_0000)
		else $error("size read wrong");
endmodule : adc_result_dma
`default_nettype wire

// File: tb/ram_result_partner.sv
// far side model: converter result source and ram write port
// assumes: one clock; the bench calls send and stop in turn
`timescale 1ns/10ps
`default_nettype none
module ram_result_partner (
	// system
	input  wire logic        clock,
	// converter results
	output logic             result_valid,
	output logic      [15:0] result_data,
	output logic             result_saturated,
	// ram write port
	input  wire logic        ram_write,
	input  wire logic [12:0] ram_address,
	input  wire logic [15:0] ram_data
);
	logic [28:0] writes[$];
	initial begin
		result_valid = 1'b0;
		result_data = 16'h0000;
		result_saturated = 1'b0;
	end
	// ram takes every write at once, no back-pressure exists
	always @(posedge clock) begin
		if (ram_write === 1'b1) begin
			writes.push_back({ram_address, ram_data});
		end
	end
	task send(input logic [15:0] d, input logic s);
		@(posedge clock);
		result_valid <= 1'b1;
		result_data <= d;
		result_saturated <= s;
	endtask : send
	// released data toggles so stale data never passes for a result
	task stop;
		@(posedge clock);
		result_valid <= 1'b0;
		result_data <= ~result_data;
		result_saturated <= 1'b0;
	endtask : stop
endmodule : ram_result_partner
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench of the converter result dma
// assumes: partner model stands on the result and ram side
`timescale 1ns/10ps
`default_nettype none
`include "adc_dma_map.svh"
module tb_top;
	typedef struct packed {
		logic        w;
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] m;
	} row_s;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        result_valid;
	logic [15:0] result_data;
	logic        result_saturated;
	logic        ram_write;
	logic [12:0] ram_address;
	logic [15:0] ram_data;
	logic        irq;
	logic [31:0] rd_v;
	logic        er_v;
	int          failures = 0;
	int          num_checks = 0;
	// reads compare d under mask m; writes only write
	row_s rows[13] = '{
		'{1'b0, `OFS_RESULT_COUNT, 32'h0, 32'hffff_ffff},
		'{1'b0, `OFS_IRQ_FLAGS, 32'h0, 32'hffff_ffff},
		'{1'b0, `OFS_IRQ_ENABLE, 32'h0, 32'hffff_ffff},
		'{1'b0, `OFS_BUFFER_START, 32'h0, 32'h0000_1fff},
		'{1'b0, `OFS_BUFFER_SIZE, 32'h0, 32'hffff_ffff},
		'{1'b0, `OFS_NEXT_ADDRESS, 32'h0, 32'h0000_1fff},
		'{1'b0, `OFS_TRANSFER_STATUS, 32'h0, 32'hffff_ffff},
		'{1'b1, `OFS_BUFFER_START, 32'h0000_0101, 32'h0},
		'{1'b0, `OFS_BUFFER_START, 32'h0000_0100, 32'h0000_1fff},
		'{1'b1, `OFS_BUFFER_SIZE, 32'h0000_f004, 32'h0},
		'{1'b0, `OFS_BUFFER_SIZE, 32'h0000_0004, 32'h0000_0fff},
		'{1'b1, `OFS_IRQ_ENABLE, 32'h0000_001e, 32'h0},
		'{1'b0, `OFS_IRQ_ENABLE, 32'h0000_001e, 32'hffff_ffff}
	};
	always #20 clock = ~clock;
	adc_result_dma i_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_valid(result_valid), .result_data(result_data),
		.result_saturated(result_saturated), .ram_write(ram_write),
		.ram_address(ram_address), .ram_data(ram_data), .irq(irq));
	ram_result_partner i_part (.clock(clock), .result_valid(result_valid),
		.result_data(result_data), .result_saturated(result_saturated),
		.ram_write(ram_write), .ram_address(ram_address),
		.ram_data(ram_data));
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// only the watchdog ends a wait that never gets an answer
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_v, x);
	endtask : rd
	task ram(input logic [12:0] a, input logic [15:0] d);
		chk({3'b000, i_part.writes.pop_front()}, {3'b000, a, d});
	endtask : ram
	// hang guard: the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd_v & rows[i].m, rows[i].d);
		end
		apb(1'b1, 16'h0040, 32'h0000_00ff);
		chk({31'h0, er_v}, 32'h1);
		rd(16'h0040, 32'h0000_0000);
		apb(1'b1, `OFS_TRANSFER_CFG, 32'h0000_0001);
		rd(`OFS_TRANSFER_CFG, 32'h0000_0000);
		rd(`OFS_TRANSFER_STATUS, 32'h0000_0001);
		i_part.send(16'ha001, 1'b0);
		i_part.stop();
		rd(`OFS_NEXT_ADDRESS, 32'h0000_0102);
		rd(`OFS_RESULT_COUNT, 32'h0000_0001);
		i_part.send(16'ha002, 1'b1);
		i_part.send(16'ha003, 1'b0);
		i_part.send(16'ha004, 1'b0);
		i_part.stop();
		repeat (2) @(posedge clock);
		ram(13'h0100, 16'ha001);
		ram(13'h0102, 16'ha002);
		ram(13'h0104, 16'ha003);
		ram(13'h0106, 16'ha004);
		chk({31'h0, irq}, 32'h1);
		rd(`OFS_IRQ_FLAGS, 32'h0000_000e);
		rd(`OFS_RESULT_COUNT, 32'h0000_0004);
		rd(`OFS_TRANSFER_STATUS, 32'h0000_0000);
		i_part.send(16'hbeef, 1'b0);
		i_part.stop();
		repeat (3) @(posedge clock);
		chk(i_part.writes.size(), 32'h0);
		rd(`OFS_IRQ_FLAGS, 32'h0000_001e);
		rd(`OFS_TRANSFER_STATUS, 32'h0000_0002);
		apb(1'b1, `OFS_IRQ_FLAGS, 32'h0000_001f);
		rd(`OFS_IRQ_FLAGS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0000);
		i_part.send(16'h1234, 1'b0);
		i_part.stop();
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_0010);
		// the write lands at the edge just passed; let it settle
		@(negedge clock);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `OFS_IRQ_FLAGS, 32'h0000_0011);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_TRANSFER_CFG, 32'h0000_0010);
		rd(`OFS_TRANSFER_STATUS, 32'h0000_0000);
		apb(1'b1, `OFS_BUFFER_START, 32'h0000_0200);
		apb(1'b1, `OFS_BUFFER_SIZE, 32'h0000_0002);
		apb(1'b1, `OFS_TRANSFER_CFG, 32'h0000_0003);
		i_part.send(16'h0c01, 1'b0);
		i_part.send(16'h0c02, 1'b0);
		i_part.send(16'h0c03, 1'b0);
		i_part.stop();
		repeat (2) @(posedge clock);
		ram(13'h0200, 16'h0c01);
		ram(13'h0202, 16'h0c02);
		ram(13'h0200, 16'h0c03);
		rd(`OFS_RESULT_COUNT, 32'h0000_0001);
		rd(`OFS_TRANSFER_STATUS, 32'h0000_0001);
		rd(`OFS_IRQ_FLAGS, 32'h0000_0006);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
